// ==== sonrx_defs.svh ====
`ifndef SONRX_DEFS_SVH
`define SONRX_DEFS_SVH

// Overview of operation
// (R1) All eight receive byte bits change together on the byte clock falling edge.
// (R2) First received bit of each byte lands on output bit 7.
// (R3) Byte clock runs at one eighth of the line bit rate.
// (R4) Far end sends 622.08 or 155.52 Mbps serial data on the line inputs.
// (R5) In bypass, line data is sampled on external recovered clock rising edge.
// (R6) Downstream framer holds frame search request high while out of frame.
// (R7) Search request high hunts alignment; low keeps the current byte boundary.
// (R8) While searching, pulse one byte period for each third A2 byte found.
// (R9) After the pulse, bytes follow the boundary of the newly found frame.
// (R10) Loss of signal declared after 128 consecutive zero bits.
// (R11) Loss cleared on at least 16 transitions within a sliding 128 bit window.
// (R12) Detect-off input high disables loss monitoring and automatic muting.
// (R13) Detect-off input low monitors the line and mutes bytes during loss.
// (R14) Optical loss input low forces every byte bus bit to zero.
// (R15) Rate select low picks lower rate mode, high picks higher rate mode.
// (R16) Bypass input disables internal recovery; external clock times the receive path.
// (R17) Search finds A1 A1 A1 A2 A2 A2 at any bit offset and sets boundary.
// (R18) Internal loss muting forces the byte bus to all zeros.

// ---------------------------------------------------------------
// Framing and byte assembly
// ---------------------------------------------------------------
`define SONRX_FRAME_PAT  48'hF6F6_F628_2828
`define SONRX_PAT_W      48
`define SONRX_BYTE_W     8
`define SONRX_BIT_FIRST  3'h0
`define SONRX_BIT_LAST   3'h7
`define SONRX_CLK_FALL   3'h4

// ---------------------------------------------------------------
// Loss of signal
// ---------------------------------------------------------------
`define SONRX_LOS_ZEROS  8'h80
`define SONRX_LOS_TRANS  8'h10
`define SONRX_LOS_WIN    128

// ---------------------------------------------------------------
// Byte buffer
// ---------------------------------------------------------------
`define SONRX_FIFO_DEPTH 8
`define SONRX_FIFO_LW    4
`define SONRX_PREFILL    4'h4

`endif

// ==== sonrx_deser.sv ====
`include "sonrx_defs.svh"

module sonrx_deser
   import sonrx_pkg::*;
(
   // Clock and reset
   input  wire logic                       clock,
   input  wire logic                       arst_n,
   // Serial line and recovered clocks
   input  wire logic                       rx_line_in_p,
   input  wire logic                       rx_line_in_n,
   input  wire logic                       ext_recovered_clk_p,
   input  wire logic                       ext_recovered_clk_n,
   input  wire logic                       recovery_aux_ref_clk,
   // Mode and control pins
   input  wire logic                       recovery_bypass,
   input  wire logic                       rate_sel,
   input  wire logic                       frame_search_req,
   input  wire logic                       sig_loss_detect_off,
   input  wire logic                       optical_sig_loss_n,
   // Byte bus towards the framer
   output      logic [`SONRX_BYTE_W-1:0]   rx_byte_out,
   output      logic                       rx_byte_clk_out,
   output      logic                       frame_align_pulse,
   // Status
   output      logic                       sig_loss,
   output      logic                       rate_hi,
   output      logic                       fifo_in_ready
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   sonrx_state_t             st;
   sonrx_state_t             next_st;
   sonrx_pins_t              pins;
   logic                     clk_lvl;
   logic                     bit_edge;
   logic                     line_bit;
   logic                     trans;
   logic                     byte_fall;
   logic                     mute;
   logic                     push;
   sonrx_word_t              push_word;
   logic                     pop;
   logic                     buf_valid;
   logic [8:0]               buf_data;
   sonrx_word_t              buf_word;
   logic [`SONRX_FIFO_LW-1:0] buf_level;

   // ---------------------------------------------------------------
   // Pin gathering
   // ---------------------------------------------------------------

   // All pins arrive from outside the clock domain
   assign pins.line_p  = rx_line_in_p;
   assign pins.line_n  = rx_line_in_n;
   assign pins.eclk_p  = ext_recovered_clk_p;
   assign pins.eclk_n  = ext_recovered_clk_n;
   assign pins.aux_clk = recovery_aux_ref_clk;
   assign pins.bypass  = recovery_bypass;
   assign pins.rate    = rate_sel;
   assign pins.search  = frame_search_req;
   assign pins.det_off = sig_loss_detect_off;
   assign pins.opt_ok  = optical_sig_loss_n;

   assign buf_word = sonrx_word_t'(buf_data);

   // ---------------------------------------------------------------
   // Receive path next state
   // ---------------------------------------------------------------

   // Synchronise, find bit edges, assemble bytes, watch the line
   always_comb
   begin
      next_st   = st;
      push      = 1'b0;
      push_word = '0;
      pop       = 1'b0;
      byte_fall = 1'b0;
      trans     = 1'b0;

      // Two stage synchronisers; only the second stage is used below
      next_st.s1 = pins;
      next_st.s2 = st.s1;

      // Bypass picks the external recovered clock, else the internal timing
      if (st.s2.bypass)
         clk_lvl = st.s2.eclk_p & ~st.s2.eclk_n;             // [R16]
      else
         clk_lvl = st.s2.aux_clk;
      next_st.clk_prev = clk_lvl;

      // Rising edge of the selected bit clock samples the line
      bit_edge = clk_lvl & ~st.clk_prev;                      // [R5]
      line_bit = st.s2.line_p & ~st.s2.line_n;

      // Mode pin reflected as status
      next_st.rate_hi = st.s2.rate;                           // [R15]

      if (bit_edge)
      begin
         // Oldest bit shifts toward the top, so it leaves on bit 7
         next_st.shreg   = {st.shreg[`SONRX_PAT_W-2:0], line_bit};  // [R2]
         next_st.bit_cnt = st.bit_cnt + 3'h1;

         // Byte complete at the last bit of the boundary
         if (st.bit_cnt == `SONRX_BIT_LAST)
         begin
            push           = 1'b1;
            push_word.data = next_st.shreg[`SONRX_BYTE_W-1:0];
         end

         // Frame hunt while requested; boundary untouched otherwise
         if (st.s2.search && (next_st.shreg == `SONRX_FRAME_PAT))   // [R7]
         begin
            push            = 1'b1;                                 // [R17]
            push_word.data  = next_st.shreg[`SONRX_BYTE_W-1:0];
            push_word.flag  = 1'b1;                                 // [R8]
            next_st.bit_cnt = `SONRX_BIT_FIRST;                     // [R9]
         end

         // Byte clock is high in the first half of each byte period
         next_st.byte_clk = (next_st.bit_cnt < `SONRX_CLK_FALL);   // [R3]
         byte_fall = st.byte_clk & ~next_st.byte_clk;

         // Consecutive zero count, saturating at the declare level
         if (line_bit)
            next_st.zcnt = '0;
         else if (st.zcnt != `SONRX_LOS_ZEROS)
            next_st.zcnt = st.zcnt + 8'h01;

         // Sliding window of transitions over the last bit periods
         trans        = line_bit ^ st.shreg[0];
         next_st.win  = {st.win[`SONRX_LOS_WIN-2:0], trans};
         next_st.tcnt = st.tcnt + {7'h00, trans}
                        - {7'h00, st.win[`SONRX_LOS_WIN-1]};
      end

      // -------------------------------------------------------------
      // Loss of signal state
      // -------------------------------------------------------------
      if (st.s2.det_off)
      begin
         next_st.los = SONRX_SIG_OK;                          // [R12]
      end
      else
      begin
         case (st.los)
            SONRX_SIG_OK:
            begin
               if (next_st.zcnt == `SONRX_LOS_ZEROS)
                  next_st.los = SONRX_SIG_LOST;               // [R10]
            end
            SONRX_SIG_LOST:
            begin
               if (next_st.tcnt >= `SONRX_LOS_TRANS)
                  next_st.los = SONRX_SIG_OK;                 // [R11]
            end
            default:
            begin
               next_st.los = SONRX_SIG_OK;
            end
         endcase
      end

      // Either loss source empties the byte bus
      mute = ((st.los == SONRX_SIG_LOST) && !st.s2.det_off)  // [R13]
             || !st.s2.opt_ok;                                // [R14]

      // -------------------------------------------------------------
      // Byte bus drain, one word per byte clock falling edge
      // -------------------------------------------------------------
      case (st.drain)
         SONRX_PREFILL:
         begin
            // Hold off until the buffer has some slack to absorb jitter
            if (byte_fall)
            begin
               next_st.out_byte  = '0;
               next_st.out_pulse = 1'b0;
               if (buf_level >= `SONRX_PREFILL)
                  next_st.drain = SONRX_RUN;
            end
         end
         SONRX_RUN:
         begin
            if (byte_fall)
            begin
               pop = 1'b1;
               if (buf_valid)
               begin
                  // Whole byte updates at once on the falling edge
                  next_st.out_byte  = mute ? '0 : buf_word.data;  // [R1] [R18]
                  next_st.out_pulse = buf_word.flag;              // [R8]
               end
               else
               begin
                  // Underrun: restart the prefill
                  next_st.out_byte  = '0;
                  next_st.out_pulse = 1'b0;
                  next_st.drain     = SONRX_PREFILL;
               end
            end
         end
         default:
         begin
            next_st.drain = SONRX_PREFILL;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------

   // Single register for all state outside the byte buffer
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         st <= '0;
      else
         st <= next_st;
   end

   // ---------------------------------------------------------------
   // Byte buffer
   // ---------------------------------------------------------------

   // Eight word buffer between the line side and the byte bus
   sonrx_fifo
   #(
      .WIDTH ($bits(sonrx_word_t)),
      .DEPTH (`SONRX_FIFO_DEPTH)
   )
   u_fifo
   (
      .clock     (clock),
      .arst_n    (arst_n),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (push_word),
      .out_ready (pop),
      .out_valid (buf_valid),
      .out_data  (buf_data),
      .level     (buf_level)
   );

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------

   // All outputs but fifo_in_ready come straight from flip-flops; fifo_in_ready is decoded from the buffer count
   assign rx_byte_out       = st.out_byte;
   assign rx_byte_clk_out   = st.byte_clk;
   assign frame_align_pulse = st.out_pulse;
   assign sig_loss          = (st.los == SONRX_SIG_LOST);
   assign rate_hi           = st.rate_hi;

endmodule

// ==== sonrx_deser_bench.sv ====
`include "sonrx_defs.svh"

module sonrx_deser_bench;
   timeunit 1ns;
   timeprecision 100ps;

`define SONRX_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
   $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end

   logic         clock = 1'b0;
   logic         arst_n = 1'b0;
   logic         bypass = 1'b1;
   logic         rate = 1'b0;
   logic         search = 1'b0;
   logic         det_off = 1'b1;
   logic         opt_n = 1'b1;
   logic         use_ext = 1'b1;
   logic         bprev = 1'b0;
   logic         lp, ln, ep, en, aux, bclk, pulse, los, rhi, frdy;
   logic [7:0]   rx_byte;
   logic [7:0]   pay[14];
   logic [8:0]   capq[$];
   int           err_total = 0;
   int           num_checks = 0;
   int           cyc = 0;

   sonrx_line_src line_src (.use_ext(use_ext), .line_p(lp), .line_n(ln), .eclk_p(ep), .eclk_n(en), .aux_clk(aux));
   sonrx_deser DUT (.clock(clock), .arst_n(arst_n), .rx_line_in_p(lp), .rx_line_in_n(ln),
      .ext_recovered_clk_p(ep), .ext_recovered_clk_n(en), .recovery_aux_ref_clk(aux), .recovery_bypass(bypass),
      .rate_sel(rate), .frame_search_req(search), .sig_loss_detect_off(det_off), .optical_sig_loss_n(opt_n),
      .rx_byte_out(rx_byte), .rx_byte_clk_out(bclk), .frame_align_pulse(pulse), .sig_loss(los),
      .rate_hi(rhi), .fifo_in_ready(frdy));

   // ------------------------------------------------
   // Clock, watchdog and byte capture
   // ------------------------------------------------
   always #5 clock = ~clock;

   // Cuts a hung run short
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         err_total++;
         $display("Error at %0t: run did not finish", $time);
         finish_test();
      end
   end

   // Captures pulse and byte at each byte clock fall, once settled
   always @(negedge clock)
   begin
      if (bprev && !bclk)
         capq.push_back({pulse, rx_byte});
      bprev = bclk;
   end

   // ------------------------------------------------
   // Tasks and expectations
   // ------------------------------------------------
   function automatic logic [8:0] exp_word(input logic [7:0] b, input logic mute);
      return {1'b0, b & {8{~mute}}};
   endfunction

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Sets the mode pins, draws a random rate and checks the rate mode
   task automatic set_ctl(input logic byp, sr, doff, opt);
      @(posedge clock);
      bypass <= byp;
      use_ext <= byp;
      search <= sr;
      det_off <= doff;
      opt_n <= opt;
      rate <= 1'($urandom);
      repeat (6) @(posedge clock);
      `SONRX_CHK(rhi, rate)
   endtask

   task automatic send(input logic [7:0] b);
      line_src.send_bits(b, 8);
   endtask

   // Junk bits, the framing bytes, then a random payload
   task automatic send_frame(input int offs);
      line_src.send_bits(8'($urandom), offs);
      for (int i = 0; i < 6; i++)
         send(8'(`SONRX_FRAME_PAT >> (40 - 8 * i)));
      foreach (pay[i])
      begin
         pay[i] = 8'($urandom);
         send(pay[i]);
      end
   endtask

   // Counts pulses, then checks the pulse byte and the bytes that follow it
   task automatic check_frame(input int want);
      int k;
      int n;
      k = -1;
      n = 0;
      foreach (capq[i])
         if (capq[i][8])
         begin
            n++;
            if (k < 0)
               k = i;
         end
      `SONRX_CHK(n, want)
      if (want > 0)
      begin
         `SONRX_CHK(k >= 0 && k + 6 < capq.size(), 1'b1)
         if (k >= 0 && k + 6 < capq.size())
         begin
            `SONRX_CHK(capq[k], 9'h128)
            for (int j = 0; j < 6; j++)
               `SONRX_CHK(capq[k + 1 + j], exp_word(pay[j], 1'b0))
         end
      end
   endtask

   // Refills the buffer with b, then checks n bytes of b through the bus
   task automatic run_bytes(input logic [7:0] b, input logic mute, input int n);
      // Eight bytes flush every word still held ahead in the buffer
      repeat (8) send(b);
      capq.delete();
      repeat (n) send(b);
      `SONRX_CHK(capq.size() > 2, 1'b1)
      foreach (capq[i])
         `SONRX_CHK(capq[i], exp_word(b, mute))
   endtask

   // ------------------------------------------------
   // Main sequence
   // ------------------------------------------------
   initial
   begin
      logic [7:0] b;
      void'($urandom(32'hf223));
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      `SONRX_CHK({rx_byte, bclk, pulse, los, rhi, frdy}, 13'h0001)
      // Hunt with either bit clock source, at a random bit offset
      for (int m = 0; m < 2; m++)
      begin
         set_ctl(1'(m), 1'b1, 1'b1, 1'b1);
         capq.delete();
         send_frame(1 + $urandom % 7);
         check_frame(1);
         $display("Alignment test done, source %0d", m);
      end
      // Request low keeps the boundary and gives no pulse
      set_ctl(1'b1, 1'b0, 1'b1, 1'b1);
      capq.delete();
      send_frame(3);
      check_frame(0);
      // Five more bits put the kept boundary back on the sent bytes
      line_src.send_bits(8'h00, 5);
      $display("Search idle test done");
      // Optical loss mutes, release restores
      b = 8'($urandom) | 8'h81;
      set_ctl(1'b0, 1'b0, 1'b1, 1'b0);
      run_bytes(b, 1'b1, 8);
      set_ctl(1'b0, 1'b0, 1'b1, 1'b1);
      run_bytes(b, 1'b0, 8);
      $display("Optical loss test done");
      // 127 zeros keep the signal, the 128th loses it; 15 transitions hold, 16 clear
      set_ctl(1'b0, 1'b0, 1'b0, 1'b1);
      send(8'h01);
      repeat (15) send(8'h00);
      line_src.send_bits(8'h00, 7);
      repeat (8) @(posedge clock);
      `SONRX_CHK(los, 1'b0)
      line_src.send_bits(8'h00, 1);
      repeat (8) @(posedge clock);
      `SONRX_CHK(los, 1'b1)
      run_bytes(8'hff, 1'b1, 6);
      send(8'h55);
      line_src.send_bits(8'h55, 6);
      repeat (8) @(posedge clock);
      `SONRX_CHK(los, 1'b1)
      line_src.send_bits(8'h00, 1);
      repeat (8) @(posedge clock);
      `SONRX_CHK(los, 1'b0)
      // Detection off: long zeros neither declare loss nor mute
      set_ctl(1'b0, 1'b0, 1'b1, 1'b1);
      // One bit puts the byte boundary back on the sent bytes
      line_src.send_bits(8'h00, 1);
      send(8'h01);
      repeat (17) send(8'h00);
      `SONRX_CHK(los, 1'b0)
      run_bytes(8'hff, 1'b0, 6);
      $display("Loss of signal test done");
      // Reset again in mid run
      @(posedge clock);
      arst_n <= 1'b0;
      repeat (4) @(posedge clock);
      `SONRX_CHK({rx_byte, bclk, pulse, los, rhi, frdy}, 13'h0001)
      arst_n <= 1'b1;
      $display("Reset test done");
      finish_test();
   end
endmodule

// ==== sonrx_deser_checker.sv ====
module sonrx_deser_checker
(
   // Clock and reset
   input wire logic         clock,
   input wire logic         arst_n,
   // Control pins
   input wire logic         rate_sel,
   input wire logic         sig_loss_detect_off,
   input wire logic         optical_sig_loss_n,
   // Byte bus and status
   input wire logic [7:0]   rx_byte_out,
   input wire logic         rx_byte_clk_out,
   input wire logic         frame_align_pulse,
   input wire logic         sig_loss,
   input wire logic         rate_hi
);
   // ------------------------------------------------
   // Byte bus, frame pulse, loss and rate checks
   // ------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   chk_bus_on_fall: assert property (!$fell(rx_byte_clk_out) |-> $stable(rx_byte_out))
      else $error("byte bus moved off a byte clock fall");
   chk_clk_high_len: assert property ($rose(rx_byte_clk_out) |-> rx_byte_clk_out[*8])
      else $error("byte clock high phase too short");
   chk_clk_low_len: assert property ($fell(rx_byte_clk_out) |-> (!rx_byte_clk_out)[*8])
      else $error("byte clock low phase too short");
   chk_pulse_rise: assert property ($rose(frame_align_pulse) |-> $fell(rx_byte_clk_out))
      else $error("frame pulse rose off a byte clock fall");
   chk_pulse_fall: assert property ($fell(frame_align_pulse) |-> $fell(rx_byte_clk_out))
      else $error("frame pulse fell off a byte clock fall");
   chk_pulse_single: assert property ($fell(rx_byte_clk_out) && $past(frame_align_pulse) |-> !frame_align_pulse)
      else $error("frame pulse longer than one byte period");
   chk_optical_mute: assert property ((!optical_sig_loss_n)[*8] ##1 $fell(rx_byte_clk_out)
      |-> rx_byte_out == 8'h00)
      else $error("byte not forced to zero on optical loss");
   chk_loss_mute: assert property ((sig_loss && !sig_loss_detect_off)[*4] ##1 ($fell(rx_byte_clk_out) && sig_loss)
      |-> rx_byte_out == 8'h00)
      else $error("byte not muted during loss of signal");
   chk_detect_off: assert property (sig_loss_detect_off[*5] |-> !sig_loss)
      else $error("loss declared with detection off");
   chk_rate_follow: assert property (rate_sel[*5] |-> rate_hi)
      else $error("rate mode does not follow rate select");

   // Main scenarios reached
   cover property ($rose(frame_align_pulse));
   cover property ($rose(sig_loss));
   cover property ($fell(sig_loss));
endmodule

bind sonrx_deser sonrx_deser_checker u_chk (.clock(clock), .arst_n(arst_n), .rate_sel(rate_sel),
   .sig_loss_detect_off(sig_loss_detect_off), .optical_sig_loss_n(optical_sig_loss_n),
   .rx_byte_out(rx_byte_out), .rx_byte_clk_out(rx_byte_clk_out), .frame_align_pulse(frame_align_pulse),
   .sig_loss(sig_loss), .rate_hi(rate_hi));

// ==== sonrx_fifo.sv ====
module sonrx_fifo
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
)
(
   // Clock and reset
   input  wire logic                           clock,
   input  wire logic                           arst_n,
   // Filling side
   input  wire logic                           in_valid,
   output      logic                           in_ready,
   input  wire logic [WIDTH-1:0]               in_data,
   // Draining side
   input  wire logic                           out_ready,
   output      logic                           out_valid,
   output      logic [WIDTH-1:0]               out_data,
   // Fill level of the store
   output      logic [$clog2(DEPTH+1)-1:0]     level
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [CW-1:0]               cnt;
      logic [WIDTH-1:0]            dout;
      logic                        dvalid;
   } sonrx_fifo_st_t;

   sonrx_fifo_st_t st;
   sonrx_fifo_st_t next_st;
   logic           push;
   logic           pop;

   // Store, pointers and registered read stage
   always_comb
   begin
      next_st = st;
      push    = in_valid && (st.cnt != CW'(DEPTH));
      pop     = (st.cnt != '0) && (!st.dvalid || out_ready);
      if (push)
      begin
         next_st.mem[st.wr] = in_data;
         next_st.wr         = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + 1'b1;
      end
      if (pop)
      begin
         next_st.dout   = st.mem[st.rd];
         next_st.dvalid = 1'b1;
         next_st.rd     = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + 1'b1;
      end
      else if (out_ready)
      begin
         next_st.dvalid = 1'b0;
      end
      next_st.cnt = st.cnt + CW'(push) - CW'(pop);
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         st <= '0;
      else
         st <= next_st;
   end

   // Full stalls the filler; data come from the read register
   assign in_ready  = (st.cnt != CW'(DEPTH));
   assign out_valid = st.dvalid;
   assign out_data  = st.dout;
   assign level     = st.cnt;

endmodule

// ==== sonrx_line_src.sv ====
module sonrx_line_src
(
   // Selects which bit clock pins carry the clock
   input  wire logic   use_ext,
   // Serial line and bit clocks
   output logic        line_p,
   output logic        line_n,
   output logic        eclk_p,
   output logic        eclk_n,
   output logic        aux_clk
);
   timeunit 1ns;
   timeprecision 100ps;

   logic   bclk = 1'b0;
   logic   bit_v = 1'b0;

   // Differential pairs follow the single-ended levels
   assign line_p = bit_v;
   assign line_n = ~bit_v;
   assign eclk_p = use_ext & bclk;
   assign eclk_n = ~(use_ext & bclk);
   assign aux_clk = ~use_ext & bclk;

   // Sends n bits from bit 7 down at 125 ns a bit; the clock stands still between calls
   task automatic send_bits(input logic [7:0] b, input int n);
      for (int i = 0; i < n; i++)
      begin
         bit_v = b[7 - i];
         #62.5 bclk = 1'b1;
         #62.5 bclk = 1'b0;
      end
      bit_v = ~bit_v; // Released line shows the inverse of the last bit
   endtask
endmodule

// ==== sonrx_pkg.sv ====
`include "sonrx_defs.svh"

package sonrx_pkg;

   // Raw pin levels, one bit each
   typedef struct packed {
      logic line_p;
      logic line_n;
      logic eclk_p;
      logic eclk_n;
      logic aux_clk;
      logic bypass;
      logic rate;
      logic search;
      logic det_off;
      logic opt_ok;
   } sonrx_pins_t;

   // Word carried through the byte buffer
   typedef struct packed {
      logic                       flag;
      logic [`SONRX_BYTE_W-1:0]   data;
   } sonrx_word_t;

   // Loss of signal states
   typedef enum logic {
      SONRX_SIG_OK   = 1'b0,
      SONRX_SIG_LOST = 1'b1
   } sonrx_los_t;

   // Output drain states
   typedef enum logic {
      SONRX_PREFILL = 1'b0,
      SONRX_RUN     = 1'b1
   } sonrx_drain_t;

   // Whole state of the receive path outside the byte buffer
   typedef struct packed {
      sonrx_pins_t                 s1;
      sonrx_pins_t                 s2;
      logic                        clk_prev;
      logic [`SONRX_PAT_W-1:0]     shreg;
      logic [2:0]                  bit_cnt;
      logic [7:0]                  zcnt;
      logic [`SONRX_LOS_WIN-1:0]   win;
      logic [7:0]                  tcnt;
      sonrx_los_t                  los;
      sonrx_drain_t                drain;
      logic [`SONRX_BYTE_W-1:0]    out_byte;
      logic                        out_pulse;
      logic                        byte_clk;
      logic                        rate_hi;
   } sonrx_state_t;

endpackage
